// >>> core/cpu_regs_pkg.sv
// Package for the banked processor register set
package cpu_regs_pkg;
   // Register bus word offsets (byte addresses)
   localparam logic [5:0] OFS_DATA0 = 6'h00;
   localparam logic [5:0] OFS_DATA1 = 6'h04;
   localparam logic [5:0] OFS_DATA2 = 6'h08;
   localparam logic [5:0] OFS_DATA3 = 6'h0c;
   localparam logic [5:0] OFS_ADDR0 = 6'h10;
   localparam logic [5:0] OFS_ADDR1 = 6'h14;
   localparam logic [5:0] OFS_FRAME = 6'h18;
   localparam logic [5:0] OFS_IPTR = 6'h1c;
   localparam logic [5:0] OFS_VBASE = 6'h20;
   localparam logic [5:0] OFS_USP = 6'h24;
   localparam logic [5:0] OFS_ISP = 6'h28;
   localparam logic [5:0] OFS_SBASE = 6'h2c;
   localparam logic [5:0] OFS_FLAGS = 6'h30;
   localparam logic [5:0] OFS_MODE0 = 6'h34;
   // Flag word bit positions
   localparam int FLG_C = 0;
   localparam int FLG_D = 1;
   localparam int FLG_Z = 2;
   localparam int FLG_S = 3;
   localparam int FLG_B = 4;
   localparam int FLG_O = 5;
   localparam int FLG_I = 6;
   localparam int FLG_U = 7;
   localparam int FLG_IPL_LO = 12;
   localparam logic [15:0] FLG_WMASK = 16'h70ff;
   localparam logic [15:0] FLG_RESET = 16'h0000;
   localparam int MODE_SWRST_BIT = 3;
   localparam logic [19:0] RESET_VEC_ADDR = 20'hffffc;
   localparam logic [19:0] FIXED_VEC_LO = 20'hfffdc;
   localparam logic [19:0] FIXED_VEC_HI = 20'hfffff;
   localparam logic [19:0] VBASE_RESET = 20'h00000;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   // Reset low time
   localparam int RESET_MIN_CYCLES = 20;
   localparam logic [4:0] RESET_CNT_MAX = 5'd20;

   // Write port from the sequencer and ALU
   typedef struct packed {
      logic we;
      logic [3:0] sel;
      logic [1:0] lanes;
      logic [15:0] data;
   } gpr_wr_t;

   typedef struct packed {
      logic upd_c;
      logic upd_zso;
      logic c;
      logic z;
      logic s;
      logic o;
   } alu_flags_t;

   typedef enum logic [1:0] {
      ST_RESET = 2'b00,
      ST_FETCH = 2'b01,
      ST_RUN = 2'b10
   } run_state_t;

   typedef struct packed {
      logic [1:0][15:0] data0;
      logic [1:0][15:0] data1;
      logic [1:0][15:0] data2;
      logic [1:0][15:0] data3;
      logic [1:0][15:0] addr0;
      logic [1:0][15:0] addr1;
      logic [1:0][15:0] frame;
      logic [19:0] iptr;
      logic [19:0] vbase;
      logic [15:0] user_stack_pointer;
      logic [15:0] interrupt_stack_pointer;
      logic [15:0] sbase;
      logic [15:0] flags;
      logic [4:0] low_cnt;
      logic swrst;
      run_state_t state;
      logic [31:0] rdata;
      logic rvalid;
   } regs_state_t;
endpackage : cpu_regs_pkg

// >>> core/cpu_banked_register_set.sv
// Banked programmer-visible register set with flag word and reset sequencing
// Operation
// - Thirteen registers; data, address and frame base come in two banks.
// - Four 16-bit data registers; data zero and one split into byte halves.
// - Data two:zero and three:one join to 32-bit operands, first upper.
// - Address registers are 16 bits; one:zero forms a 32-bit address.
// - Frame base is a banked 16-bit base for frame-relative addressing.
// - Instruction pointer is 20 bits, address of next instruction.
// - Vector base is 20 bits, start of relocatable vector table.
// - User and interrupt stack pointers; flag bit 7 picks user when set.
// - Static base is a 16-bit base for static-relative addressing.
// - Flag bit 0 captures ALU carry, borrow or shifted-out bit.
// - Debug flag asks single-step after each instruction; cleared on acknowledge.
// - Flag bit 2 set when result is zero, else cleared.
// - Flag bit 3 set when result is negative, else cleared.
// - Flag bit 4 selects register bank zero or one.
// - Flag bit 5 set on arithmetic overflow, else cleared.
// - Flag bit 6 enables maskable interrupts; cleared on acknowledge.
// - Stack select cleared on hardware acknowledge or software interrupt 0-31.
// - Bits 12-14 hold priority level; accept only higher priority requests.
// - Flag bits 8-11 and 15 are reserved with no function.
// - Reset held low 20 cycles; then fetch reset vector and start.
// - Fixed vectors come from a fixed top range, not the vector base.
// - Mode register bit 3 write gives software reset like hardware reset.
`timescale 1ns/100ps
`default_nettype none
module cpu_banked_register_set (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Avalon-MM register slave
   input wire logic [5:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // Register read port
   input wire logic [3:0] rd_sel,
   input wire logic rd_wide,
   output logic [31:0] rd_data,
   // Register write port and flag results
   input wire cpu_regs_pkg::gpr_wr_t gpr_wr,
   input wire cpu_regs_pkg::alu_flags_t alu_flags,
   input wire logic flags_we,
   input wire logic [15:0] flags_wdata,
   // Program flow
   input wire logic ip_load,
   input wire logic [19:0] ip_next,
   input wire logic vec_data_valid,
   input wire logic [19:0] vec_data,
   input wire logic insn_done,
   input wire logic sp_we,
   input wire logic [15:0] sp_wdata,
   // Interrupt control
   input wire logic irq_req,
   input wire logic [2:0] irq_prio,
   input wire logic irq_maskable,
   input wire logic irq_ack,
   input wire logic swi_exec,
   input wire logic [5:0] swi_num,
   // Status toward the sequencer
   output logic [19:0] instruction_pointer,
   output logic [19:0] vector_base_reg,
   output logic [15:0] stack_pointer,
   output logic [15:0] frame_base_reg,
   output logic [15:0] static_base_reg,
   output logic [15:0] processor_flag_word,
   output logic [19:0] vec_fetch_addr,
   output logic vec_fetch_req,
   output logic cpu_running,
   output logic irq_accept,
   output logic step_irq_req,
   output logic ram_keep
);
   cpu_regs_pkg::regs_state_t s_q;
   cpu_regs_pkg::regs_state_t s_d;
   logic bank;
   logic [2:0] processor_priority_level;

   assign bank = s_q.flags[cpu_regs_pkg::FLG_B];
   assign processor_priority_level = s_q.flags[cpu_regs_pkg::FLG_IPL_LO +: 3];

   // Outputs
   assign instruction_pointer = s_q.iptr;
   assign vector_base_reg = s_q.vbase;
   assign stack_pointer = s_q.flags[cpu_regs_pkg::FLG_U] ? s_q.user_stack_pointer : s_q.interrupt_stack_pointer;
   assign frame_base_reg = s_q.frame[bank];
   assign static_base_reg = s_q.sbase;
   assign processor_flag_word = s_q.flags;
   // Reset vector sits in the fixed range; vector base plays no part
   assign vec_fetch_addr = cpu_regs_pkg::RESET_VEC_ADDR;
   assign vec_fetch_req = (s_q.state == cpu_regs_pkg::ST_FETCH);
   assign cpu_running = (s_q.state == cpu_regs_pkg::ST_RUN);
   // Priority compare; non-maskable requests skip the enable flag
   assign irq_accept = irq_req && (irq_prio > processor_priority_level) &&
      (!irq_maskable || s_q.flags[cpu_regs_pkg::FLG_I]);
   assign step_irq_req = insn_done && s_q.flags[cpu_regs_pkg::FLG_D];
   assign ram_keep = s_q.swrst;
   assign avs_readdata = s_q.rdata;
   // One wait cycle for reads so read data comes from a flop
   assign avs_waitrequest = avs_read && !s_q.rvalid;
   assign rd_data = s_q.rdata;

   // Read mux for one register select
   function automatic logic [15:0] pick(input cpu_regs_pkg::regs_state_t s,
                                        input logic [3:0] sel, input logic b);
      logic [15:0] r;
      r = 16'h0000;
      unique case (sel)
         4'h0: r = s.data0[b];
         4'h1: r = s.data1[b];
         4'h2: r = s.data2[b];
         4'h3: r = s.data3[b];
         4'h4: r = s.addr0[b];
         4'h5: r = s.addr1[b];
         4'h6: r = s.frame[b];
         4'h7: r = s.sbase;
         4'h8: r = s.user_stack_pointer;
         4'h9: r = s.interrupt_stack_pointer;
         4'ha: r = s.flags;
         default: r = 16'h0000;
      endcase
      return r;
   endfunction : pick

   // Byte-lane write of a 16-bit register
   function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [1:0] ln);
      return {ln[1] ? nw[15:8] : old[15:8], ln[0] ? nw[7:0] : old[7:0]};
   endfunction : merge

   always_comb begin
      logic [15:0] f;
      logic [15:0] wv;
      logic [1:0] wl;
      logic hold_rst;
      s_d = s_q;
      f = s_q.flags;
      wv = 16'h0000;
      wl = 2'b00;
      hold_rst = 1'b0;
      s_d.rvalid = 1'b0;
      // Register port: wide select joins bank words, first-named upper
      if (rd_wide) begin
         unique case (rd_sel[1:0])
            2'b00: s_d.rdata = {s_q.data2[bank], s_q.data0[bank]};
            2'b01: s_d.rdata = {s_q.data3[bank], s_q.data1[bank]};
            default: s_d.rdata = {s_q.addr1[bank], s_q.addr0[bank]};
         endcase
      end else begin
         s_d.rdata = {16'h0000, pick(s_q, rd_sel, bank)};
      end
      // Bus reads override the port reading for that cycle
      if (avs_read && !s_q.rvalid) begin
         s_d.rvalid = 1'b1;
         unique case (avs_address)
            cpu_regs_pkg::OFS_DATA0: s_d.rdata = {16'h0000, s_q.data0[bank]};
            cpu_regs_pkg::OFS_DATA1: s_d.rdata = {16'h0000, s_q.data1[bank]};
            cpu_regs_pkg::OFS_DATA2: s_d.rdata = {16'h0000, s_q.data2[bank]};
            cpu_regs_pkg::OFS_DATA3: s_d.rdata = {16'h0000, s_q.data3[bank]};
            cpu_regs_pkg::OFS_ADDR0: s_d.rdata = {16'h0000, s_q.addr0[bank]};
            cpu_regs_pkg::OFS_ADDR1: s_d.rdata = {16'h0000, s_q.addr1[bank]};
            cpu_regs_pkg::OFS_FRAME: s_d.rdata = {16'h0000, s_q.frame[bank]};
            cpu_regs_pkg::OFS_IPTR: s_d.rdata = {12'h000, s_q.iptr};
            cpu_regs_pkg::OFS_VBASE: s_d.rdata = {12'h000, s_q.vbase};
            cpu_regs_pkg::OFS_USP: s_d.rdata = {16'h0000, s_q.user_stack_pointer};
            cpu_regs_pkg::OFS_ISP: s_d.rdata = {16'h0000, s_q.interrupt_stack_pointer};
            cpu_regs_pkg::OFS_SBASE: s_d.rdata = {16'h0000, s_q.sbase};
            cpu_regs_pkg::OFS_FLAGS: s_d.rdata = {16'h0000, s_q.flags};
            default: s_d.rdata = 32'h00000000;
         endcase
      end
      // Sequencer register writes land in the current bank only
      if (gpr_wr.we) begin
         wv = gpr_wr.data;
         wl = gpr_wr.lanes;
         unique case (gpr_wr.sel)
            4'h0: s_d.data0[bank] = merge(s_q.data0[bank], wv, wl);
            4'h1: s_d.data1[bank] = merge(s_q.data1[bank], wv, wl);
            4'h2: s_d.data2[bank] = wv;
            4'h3: s_d.data3[bank] = wv;
            4'h4: s_d.addr0[bank] = wv;
            4'h5: s_d.addr1[bank] = wv;
            4'h6: s_d.frame[bank] = wv;
            4'h7: s_d.sbase = wv;
            default: s_d.sbase = s_q.sbase;
         endcase
      end
      // Bus writes, low half-word lanes; vector base takes bits 19:0 whole
      if (avs_write) begin
         wv = avs_writedata[15:0];
         wl = avs_byteenable[1:0];
         unique case (avs_address)
            cpu_regs_pkg::OFS_DATA0: s_d.data0[bank] = merge(s_q.data0[bank], wv, wl);
            cpu_regs_pkg::OFS_DATA1: s_d.data1[bank] = merge(s_q.data1[bank], wv, wl);
            cpu_regs_pkg::OFS_DATA2: s_d.data2[bank] = merge(s_q.data2[bank], wv, wl);
            cpu_regs_pkg::OFS_DATA3: s_d.data3[bank] = merge(s_q.data3[bank], wv, wl);
            cpu_regs_pkg::OFS_ADDR0: s_d.addr0[bank] = merge(s_q.addr0[bank], wv, wl);
            cpu_regs_pkg::OFS_ADDR1: s_d.addr1[bank] = merge(s_q.addr1[bank], wv, wl);
            cpu_regs_pkg::OFS_FRAME: s_d.frame[bank] = merge(s_q.frame[bank], wv, wl);
            cpu_regs_pkg::OFS_VBASE: s_d.vbase = avs_writedata[19:0];
            cpu_regs_pkg::OFS_USP: s_d.user_stack_pointer = merge(s_q.user_stack_pointer, wv, wl);
            cpu_regs_pkg::OFS_ISP: s_d.interrupt_stack_pointer = merge(s_q.interrupt_stack_pointer, wv, wl);
            cpu_regs_pkg::OFS_SBASE: s_d.sbase = merge(s_q.sbase, wv, wl);
            cpu_regs_pkg::OFS_FLAGS: f = merge(f, wv, wl) & cpu_regs_pkg::FLG_WMASK;
            cpu_regs_pkg::OFS_MODE0: hold_rst = avs_byteenable[0] &&
               avs_writedata[cpu_regs_pkg::MODE_SWRST_BIT];
            default: hold_rst = 1'b0;
         endcase
      end
      // Active stack pointer update
      if (sp_we) begin
         if (s_q.flags[cpu_regs_pkg::FLG_U]) s_d.user_stack_pointer = sp_wdata;
         else s_d.interrupt_stack_pointer = sp_wdata;
      end
      // Flag word: whole write, then ALU results, then interrupt effects
      if (flags_we) f = flags_wdata & cpu_regs_pkg::FLG_WMASK;
      if (alu_flags.upd_c) f[cpu_regs_pkg::FLG_C] = alu_flags.c;
      if (alu_flags.upd_zso) begin
         f[cpu_regs_pkg::FLG_Z] = alu_flags.z;
         f[cpu_regs_pkg::FLG_S] = alu_flags.s;
         f[cpu_regs_pkg::FLG_O] = alu_flags.o;
      end
      if (irq_ack) begin
         f[cpu_regs_pkg::FLG_D] = 1'b0;
         f[cpu_regs_pkg::FLG_I] = 1'b0;
         f[cpu_regs_pkg::FLG_U] = 1'b0;
      end
      if (swi_exec && swi_num < 6'd32) f[cpu_regs_pkg::FLG_U] = 1'b0;
      s_d.flags = f;
      // Instruction pointer
      if (ip_load) s_d.iptr = ip_next;
      // Reset sequencing: count low cycles, then fetch the vector
      unique case (s_q.state)
         cpu_regs_pkg::ST_RESET: begin
            // Too short a low phase is forgotten, not added to the next one
            if (s_q.low_cnt >= cpu_regs_pkg::RESET_CNT_MAX) s_d.state = cpu_regs_pkg::ST_FETCH;
            else s_d.low_cnt = 5'd0;
         end
         cpu_regs_pkg::ST_FETCH: begin
            if (vec_data_valid) begin
               s_d.iptr = vec_data;
               s_d.state = cpu_regs_pkg::ST_RUN;
            end
         end
         cpu_regs_pkg::ST_RUN: begin
            s_d.state = cpu_regs_pkg::ST_RUN;
         end
         default: s_d.state = cpu_regs_pkg::ST_RESET;
      endcase
      // Software reset acts as a hardware reset that ran its full low time
      if (hold_rst) begin
         s_d = '0;
         s_d.swrst = 1'b1;
         s_d.low_cnt = cpu_regs_pkg::RESET_CNT_MAX;
         s_d.state = cpu_regs_pkg::ST_RESET;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         // Count how long the pin stayed low, saturating
         s_q <= '0;
         s_q.state <= cpu_regs_pkg::ST_RESET;
         if (s_q.state == cpu_regs_pkg::ST_RESET) begin
            s_q.low_cnt <= (s_q.low_cnt < cpu_regs_pkg::RESET_CNT_MAX) ?
               s_q.low_cnt + 5'd1 : s_q.low_cnt;
         end else begin
            // Power-up, vector fetch or running core: this is the first low edge
            s_q.low_cnt <= 5'd1;
         end
      end else begin
         s_q <= s_d;
      end
   end

   // Checks
   sequence fetch_then_run;
      vec_data_valid ##1 cpu_running;
   endsequence
   chk_bank_sel_frame: assert property (@(posedge ref_clk) disable iff (!rst_n)
      frame_base_reg == s_q.frame[processor_flag_word[4]])
      else $error("frame base not from selected bank");
   chk_ack_clears_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq_ack |=> (processor_flag_word[7:6] == 2'b00 && !processor_flag_word[1]))
      else $error("acknowledge did not clear flags");
   chk_swi_clears_u: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (swi_exec && swi_num < 6'd32 && !avs_write) |=> !processor_flag_word[7])
      else $error("software interrupt did not clear stack select");
   chk_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (processor_flag_word & 16'h8f00) == 16'h0000)
      else $error("reserved flag bits set");
   chk_prio_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
      irq_accept |-> irq_prio > processor_flag_word[14:12])
      else $error("interrupt accepted at or below level");
   chk_stack_select: assert property (@(posedge ref_clk) disable iff (!rst_n)
      stack_pointer == (processor_flag_word[7] ? s_q.user_stack_pointer : s_q.interrupt_stack_pointer))
      else $error("wrong stack pointer active");
   chk_reset_vector: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (vec_fetch_req && vec_data_valid && !avs_write) |-> fetch_then_run)
      else $error("reset vector did not start execution");
   chk_zero_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (alu_flags.upd_zso && !irq_ack && !avs_write) |=> processor_flag_word[2] == $past(alu_flags.z))
      else $error("zero flag not captured");
   chk_carry_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (alu_flags.upd_c && !avs_write) |=> processor_flag_word[0] == $past(alu_flags.c))
      else $error("carry flag not captured");
   chk_step_req: assert property (@(posedge ref_clk) disable iff (!rst_n)
      step_irq_req |-> processor_flag_word[1])
      else $error("single step without debug flag");
   chk_fixed_vec: assert property (@(posedge ref_clk) disable iff (!rst_n)
      vec_fetch_req |-> vec_fetch_addr >= cpu_regs_pkg::FIXED_VEC_LO)
      else $error("vector fetch outside fixed range");
   sequence swrst_then_fetch;
      ram_keep && instruction_pointer == 20'h00000 ##1 vec_fetch_req;
   endsequence
   chk_sw_reset_seq: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (avs_write && avs_address == cpu_regs_pkg::OFS_MODE0 && avs_byteenable[0] &&
       avs_writedata[cpu_regs_pkg::MODE_SWRST_BIT]) |=> swrst_then_fetch)
      else $error("software reset did not restart the fetch");
endmodule : cpu_banked_register_set
`default_nettype wire

// >>> verif/seq_alu_model.sv
// Behavioural model of the sequencer side answering reset vector fetches
`timescale 1ns/100ps
`default_nettype none
module seq_alu_model (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Vector fetch handshake
   input wire logic vec_fetch_req,
   input wire logic [19:0] vec_fetch_addr,
   input wire logic [3:0] reply_delay,
   input wire logic [19:0] reset_target,
   output logic vec_data_valid,
   output logic [19:0] vec_data
);
   logic [3:0] wait_cnt;
   always @(posedge ref_clk) begin
      vec_data_valid <= 1'b0;
      if (!rst_n) begin
         wait_cnt <= 4'h0;
         vec_data <= 20'h5a5a5;
      end else if (vec_data_valid) begin
         // Released bus shows the inverse, never the stale word
         vec_data <= ~vec_data;
      end else if (vec_fetch_req) begin
         if (wait_cnt == reply_delay) begin
            vec_data_valid <= 1'b1;
            // Only the fixed reset slot holds the start address
            vec_data <= (vec_fetch_addr == 20'hffffc) ? reset_target : 20'h00000;
            wait_cnt <= 4'h0;
         end else begin
            wait_cnt <= wait_cnt + 4'h1;
         end
      end
   end
endmodule : seq_alu_model
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the banked processor register set
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [5:0] avs_address = 6'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'h0;
   logic [31:0] avs_readdata, rd_data, rv;
   logic avs_waitrequest, rd_wide = 1'b0;
   logic [3:0] rd_sel = 4'h0;
   logic [3:0] reply_delay = 4'h0;
   cpu_regs_pkg::gpr_wr_t gpr_wr = '0;
   cpu_regs_pkg::alu_flags_t alu_flags = '0;
   logic flags_we = 1'b0, ip_load = 1'b0, insn_done = 1'b0, sp_we = 1'b0;
   logic [15:0] flags_wdata = 16'h0, sp_wdata = 16'h0, stack_pointer, frame_base_reg;
   logic [15:0] static_base_reg, processor_flag_word;
   logic [19:0] ip_next = 20'h0, vec_data, instruction_pointer, vector_base_reg;
   logic [19:0] vec_fetch_addr, fetch_seen;
   logic vec_data_valid, vec_fetch_req, cpu_running, irq_accept, step_irq_req, ram_keep;
   logic irq_req = 1'b0, irq_maskable = 1'b0, irq_ack = 1'b0, swi_exec = 1'b0;
   logic [2:0] irq_prio = 3'h0;
   logic [5:0] swi_num = 6'h00;
   int mismatches = 0;
   int total_checks = 0;
   localparam logic [19:0] TARGET = 20'h8c3a4;
   localparam logic [5:0] OFS [11] = '{6'h00, 6'h04, 6'h08, 6'h0c, 6'h10, 6'h14, 6'h18,
      6'h20, 6'h24, 6'h28, 6'h2c};

   always #12.5 ref_clk = ~ref_clk;

   cpu_banked_register_set dut_u (.ref_clk(ref_clk), .rst_n(rst_n),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rd_sel(rd_sel),
      .rd_wide(rd_wide), .rd_data(rd_data), .gpr_wr(gpr_wr), .alu_flags(alu_flags),
      .flags_we(flags_we), .flags_wdata(flags_wdata), .ip_load(ip_load), .ip_next(ip_next),
      .vec_data_valid(vec_data_valid), .vec_data(vec_data), .insn_done(insn_done),
      .sp_we(sp_we), .sp_wdata(sp_wdata), .irq_req(irq_req), .irq_prio(irq_prio),
      .irq_maskable(irq_maskable), .irq_ack(irq_ack), .swi_exec(swi_exec), .swi_num(swi_num),
      .instruction_pointer(instruction_pointer), .vector_base_reg(vector_base_reg),
      .stack_pointer(stack_pointer), .frame_base_reg(frame_base_reg),
      .static_base_reg(static_base_reg), .processor_flag_word(processor_flag_word),
      .vec_fetch_addr(vec_fetch_addr), .vec_fetch_req(vec_fetch_req),
      .cpu_running(cpu_running), .irq_accept(irq_accept), .step_irq_req(step_irq_req),
      .ram_keep(ram_keep));

   seq_alu_model partner_u (.ref_clk(ref_clk), .rst_n(rst_n), .vec_fetch_req(vec_fetch_req),
      .vec_fetch_addr(vec_fetch_addr), .reply_delay(reply_delay), .reset_target(TARGET),
      .vec_data_valid(vec_data_valid), .vec_data(vec_data));

   task summarize;
      if (mismatches == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // Bus cycle: request held until waitrequest is sampled low at a rising edge
   task bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, input logic [3:0] be,
            output logic [31:0] rd);
      logic done;
      avs_address <= a;
      avs_write <= wr;
      avs_read <= !wr;
      avs_writedata <= wd;
      avs_byteenable <= be;
      done = 1'b0;
      // No cycle count assumed; only the watchdog ends a stuck wait
      while (!done) begin
         @(posedge ref_clk);
         done = (avs_waitrequest === 1'b0);
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus

   task rdp(input logic [3:0] s, input logic w, input logic [31:0] exp);
      rd_sel <= s;
      rd_wide <= w;
      repeat (2) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(rd_data, exp);
      @(posedge ref_clk);
   endtask : rdp

   task gw(input logic [3:0] s, input logic [1:0] ln, input logic [15:0] d);
      gpr_wr <= '{we: 1'b1, sel: s, lanes: ln, data: d};
      @(posedge ref_clk);
      gpr_wr <= '0;
      @(posedge ref_clk);
   endtask : gw

   task setf(input logic [15:0] v);
      flags_we <= 1'b1;
      flags_wdata <= v;
      @(posedge ref_clk);
      flags_we <= 1'b0;
      @(posedge ref_clk);
   endtask : setf

   // Waits for the vector fetch and the start of execution
   task wait_run;
      int n;
      fetch_seen = 20'h00000;
      for (n = 0; n < 60 && cpu_running !== 1'b1; n++) begin
         @(negedge ref_clk);
         if (vec_fetch_req === 1'b1) fetch_seen = vec_fetch_addr;
      end
      chk(32'(fetch_seen >= 20'hfffdc), 32'h1);
      chk(32'(instruction_pointer), 32'(TARGET));
      @(posedge ref_clk);
   endtask : wait_run

   task t_reset;
      repeat (12) @(posedge ref_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk);
      chk(32'({cpu_running, vec_fetch_req}), 32'h0);
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      wait_run();
      bus(1'b0, 6'h30, 32'h0, 4'hf, rv);
      chk(rv, 32'h0);
   endtask : t_reset

   // Eleven registers written first, then all eleven read back to expose aliasing
   task t_regs;
      for (int i = 0; i < 11; i++) bus(1'b1, OFS[i], {12'hfed, 4'(i), 16'h5a00 | 16'(i)}, 4'hf, rv);
      for (int i = 0; i < 11; i++) begin
         bus(1'b0, OFS[i], 32'h0, 4'hf, rv);
         chk(rv, (i == 7) ? {12'h0, 4'(i), 16'h5a00 | 16'(i)} : 32'h5a00 | 32'(i));
      end
      chk(32'(vector_base_reg), 32'h00075a07);
      chk(32'(static_base_reg), 32'h00005a0a);
      chk(32'(frame_base_reg), 32'h5a06);
      bus(1'b1, 6'h1c, 32'h12345, 4'hf, rv);
      bus(1'b0, 6'h1c, 32'h0, 4'hf, rv);
      chk(rv, 32'(TARGET));
      bus(1'b1, 6'h38, 32'hffffffff, 4'hf, rv);
      bus(1'b0, 6'h38, 32'h0, 4'hf, rv);
      chk(rv, 32'h0);
      bus(1'b1, 6'h30, 32'hffffffef, 4'hf, rv);
      bus(1'b0, 6'h30, 32'h0, 4'hf, rv);
      chk(rv, 32'h70ef);
      chk(32'(stack_pointer), 32'h5a08);
      setf(16'h0000);
      chk(32'(stack_pointer), 32'h5a09);
      sp_we <= 1'b1;
      sp_wdata <= 16'hc3c3;
      @(posedge ref_clk);
      sp_we <= 1'b0;
      bus(1'b0, 6'h28, 32'h0, 4'hf, rv);
      chk(rv, 32'hc3c3);
   endtask : t_regs

   task t_wide;
      gw(4'h0, 2'b11, 16'h0a0a);
      gw(4'h1, 2'b11, 16'h1c1c);
      gw(4'h2, 2'b11, 16'h2b2b);
      gw(4'h3, 2'b11, 16'h3d3d);
      gw(4'h4, 2'b11, 16'h4e4e);
      gw(4'h5, 2'b11, 16'h5f5f);
      gw(4'h0, 2'b01, 16'hffee);
      gw(4'h1, 2'b10, 16'h77ff);
      rdp(4'h0, 1'b1, 32'h2b2b0aee);
      rdp(4'h1, 1'b1, 32'h3d3d771c);
      rdp(4'h2, 1'b1, 32'h5f5f4e4e);
   endtask : t_wide

   task t_bank;
      setf(16'h0010);
      gw(4'h0, 2'b11, 16'hb1b1);
      gw(4'h6, 2'b11, 16'hf1f1);
      chk(32'(frame_base_reg), 32'hf1f1);
      rdp(4'h0, 1'b0, 32'hb1b1);
      setf(16'h0000);
      rdp(4'h0, 1'b0, 32'h0aee);
      chk(32'(frame_base_reg), 32'h5a06);
   endtask : t_bank

   task t_alu(input logic [5:0] f, input logic [15:0] exp);
      alu_flags <= f;
      @(posedge ref_clk);
      alu_flags <= '0;
      @(negedge ref_clk);
      chk(32'(processor_flag_word), 32'(exp));
      @(posedge ref_clk);
   endtask : t_alu

   task t_irq;
      setf(16'h30c2);
      irq_req <= 1'b1;
      irq_maskable <= 1'b1;
      irq_prio <= 3'h3;
      insn_done <= 1'b1;
      @(negedge ref_clk);
      chk(32'({irq_accept, step_irq_req}), 32'h1);
      @(posedge ref_clk);
      irq_prio <= 3'h4;
      insn_done <= 1'b0;
      @(negedge ref_clk);
      chk(32'({irq_accept, step_irq_req}), 32'h2);
      @(posedge ref_clk);
      setf(16'h3082);
      @(negedge ref_clk);
      chk(32'(irq_accept), 32'h0);
      @(posedge ref_clk);
      irq_maskable <= 1'b0;
      @(negedge ref_clk);
      chk(32'(irq_accept), 32'h1);
      @(posedge ref_clk);
      irq_maskable <= 1'b1;
      setf(16'h30c2);
      irq_ack <= 1'b1;
      @(posedge ref_clk);
      irq_ack <= 1'b0;
      irq_req <= 1'b0;
      @(negedge ref_clk);
      chk(32'(processor_flag_word), 32'h3000);
      for (int n = 31; n < 33; n++) begin
         @(posedge ref_clk);
         setf(16'h0080);
         swi_exec <= 1'b1;
         swi_num <= 6'(n);
         @(posedge ref_clk);
         swi_exec <= 1'b0;
         @(negedge ref_clk);
         chk(32'(processor_flag_word), (n == 31) ? 32'h0 : 32'h80);
      end
   endtask : t_irq

   // Software reset clears everything but flags RAM as kept
   task t_swrst;
      @(posedge ref_clk);
      ip_load <= 1'b1;
      ip_next <= 20'habcde;
      @(posedge ref_clk);
      ip_load <= 1'b0;
      @(negedge ref_clk);
      chk(32'(instruction_pointer), 32'habcde);
      @(posedge ref_clk);
      reply_delay <= 4'h4;
      bus(1'b1, 6'h34, 32'h8, 4'h1, rv);
      wait_run();
      chk(32'(ram_keep), 32'h1);
      rdp(4'h0, 1'b0, 32'h0);
      chk(32'(processor_flag_word), 32'h0);
   endtask : t_swrst

   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      summarize();
   end

   initial begin
      @(posedge ref_clk);
      t_reset();
      t_regs();
      t_wide();
      t_bank();
      t_alu(6'h3f, 16'h002d);
      t_alu(6'h20, 16'h002c);
      t_alu(6'h30, 16'h0000);
      t_irq();
      t_swrst();
      summarize();
   end
endmodule : tb_top
`default_nettype wire
